// File: hdl/dcf_regs.svh
// Constants of the dual-clock FIFO with mailboxes
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH
`define DCF_WORD_W 36
`define DCF_DEPTH 2048
`define DCF_X_RESET 8
`define DCF_Y_RESET 8
`define DCF_OFS_X_LSB 0
`define DCF_OFS_Y_LSB 16
`endif

// File: hdl/dcf_pkg.sv
// Types shared by the dual-clock FIFO with mailboxes
`include "dcf_regs.svh"
package dcf_pkg;
	// Port-A pins as sampled, clock included
	typedef struct packed {
		logic                   clk;
		logic                   selN;
		logic                   en;
		logic                   wr;
		logic                   mbx;
		logic                   ofsLoad;
		logic                   serEnN;
		logic                   serData;
		logic [`DCF_WORD_W-1:0] data;
	} dcf_porta_t;
	// Port-B pins as sampled, clock included
	typedef struct packed {
		logic                   clk;
		logic                   selN;
		logic                   en;
		logic                   wr;
		logic                   mbx;
		logic                   rtMark;
		logic                   rtGo;
		logic [`DCF_WORD_W-1:0] data;
	} dcf_portb_t;
endpackage

// File: hdl/dcf_fifo_mailbox.sv
// Dual-clock FIFO with two mailboxes, sampled on the system clock
`include "dcf_regs.svh"
module dcf_fifo_mailbox #(
	parameter int DEPTH  = `DCF_DEPTH,
	parameter int X_INIT = `DCF_X_RESET,
	parameter int Y_INIT = `DCF_Y_RESET
) (
	// System
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	// Port A control pins
	input  wire logic                   port_a_clock,
	input  wire logic                   port_a_select_n,
	input  wire logic                   port_a_master_enable,
	input  wire logic                   port_a_write,
	input  wire logic                   port_a_mailbox_select,
	input  wire logic                   port_a_offset_load,
	input  wire logic                   serial_enable_n,
	input  wire logic                   serial_data,
	// Port A data, split two-way pin
	input  wire logic [`DCF_WORD_W-1:0] port_a_data_in,
	output logic      [`DCF_WORD_W-1:0] port_a_data_out,
	output logic                        port_a_data_oe,
	// Port A flags
	output logic                        input_ready,
	output logic                        almost_full_n,
	output logic                        b_to_a_mail_flag_n,
	// Port B control pins
	input  wire logic                   port_b_clock,
	input  wire logic                   port_b_select_n,
	input  wire logic                   port_b_master_enable,
	input  wire logic                   port_b_write,
	input  wire logic                   port_b_mailbox_select,
	input  wire logic                   port_b_retransmit_mark,
	input  wire logic                   port_b_retransmit,
	// Port B data, split two-way pin
	input  wire logic [`DCF_WORD_W-1:0] port_b_data_in,
	output logic      [`DCF_WORD_W-1:0] port_b_data_out,
	output logic                        port_b_data_oe,
	// Port B flags
	output logic                        output_ready,
	output logic                        almost_empty_n,
	output logic                        a_to_b_mail_flag_n
);
	localparam int AW = $clog2(DEPTH);
	localparam int W  = `DCF_WORD_W;
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	// Depth must be a power of two so pointers wrap cleanly
	if (DEPTH < 4 || (1 << AW) != DEPTH || X_INIT >= DEPTH || Y_INIT >= DEPTH) begin : g_chk
		$error("dcf_fifo_mailbox: unsupported depth or threshold");
	end

	// All register state of the block
	typedef struct packed {
		dcf_pkg::dcf_porta_t [2:0] aPipe;    // Three sample stages, port A
		dcf_pkg::dcf_portb_t [2:0] bPipe;    // Three sample stages, port B
		logic                      aClk;     // Agreed port-A clock level
		logic                      bClk;     // Agreed port-B clock level
		logic [AW:0]               wrPtr;    // Write position, wrap bit on top
		logic [AW:0]               rdPtr;    // Read position
		logic [AW:0]               markPtr;  // Retransmit start
		logic                      markOn;   // Retransmit mode
		logic [AW:0]               rdSyncA1; // Gray read side, A stage 1
		logic [AW:0]               rdSyncA2; // Gray read side, A stage 2
		logic [AW:0]               wrSyncB1; // Gray write side, B stage 1
		logic [AW:0]               wrSyncB2; // Gray write side, B stage 2
		logic [AW-1:0]             ofsX;     // Almost-empty threshold
		logic [AW-1:0]             ofsY;     // Almost-full threshold
		logic                      irF;      // Not full
		logic                      afN;      // Almost full, active low
		logic                      orF;      // Not empty
		logic                      aeN;      // Almost empty, active low
		logic [W-1:0]              mail1;    // Mail from A to B
		logic [W-1:0]              mail2;    // Mail from B to A
		logic                      mail1Full;
		logic                      mail2Full;
		logic [W-1:0]              aOut;     // Port-A read data
		logic [W-1:0]              bOut;     // Port-B read data
	} dcf_state_t;

	dcf_state_t          s_r;
	dcf_state_t          s_nxt;
	logic [W-1:0]        mem [DEPTH];         // The FIFO store
	dcf_pkg::dcf_porta_t aIn;                 // Raw port-A pins
	dcf_pkg::dcf_portb_t bIn;                 // Raw port-B pins
	dcf_pkg::dcf_porta_t a;                   // Settled port-A sample
	dcf_pkg::dcf_portb_t b;                   // Settled port-B sample
	logic                aAgree;
	logic                bAgree;
	logic                aEdge;
	logic                bEdge;
	logic                aAct;
	logic                bAct;
	logic                aFifoWr;
	logic                aMailWr;
	logic                aMailRd;
	logic                aOfsWr;
	logic                aSer;
	logic                bFifoRd;
	logic                bMailWr;
	logic                bMailRd;
	logic                bMark;
	logic                bRt;
	logic                bRelease;
	logic [W-1:0]        memRd;
	logic [AW:0]         wrNxt;
	logic [AW:0]         rdNxt;
	logic [AW:0]         aFree;
	logic [AW:0]         bCnt;

	// Binary to Gray, used for both pointers
	function automatic logic [AW:0] bin2gray(input logic [AW:0] v);
		return v ^ (v >> 1);
	endfunction

	// Gray back to binary
	function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
		logic [AW:0] v;
		v = '0;
		v[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			v[i] = v[i+1] ^ g[i];
		end
		return v;
	endfunction

	// Pins are packed in struct order and sampled together
	assign aIn = {port_a_clock, port_a_select_n, port_a_master_enable, port_a_write,
		port_a_mailbox_select, port_a_offset_load, serial_enable_n, serial_data, port_a_data_in};
	assign bIn = {port_b_clock, port_b_select_n, port_b_master_enable, port_b_write,
		port_b_mailbox_select, port_b_retransmit_mark, port_b_retransmit, port_b_data_in};
	assign a = s_r.aPipe[2];
	assign b = s_r.bPipe[2];

	// A clock level counts once stages two and three agree
	assign aAgree = s_r.aPipe[1].clk == s_r.aPipe[2].clk;
	assign bAgree = s_r.bPipe[1].clk == s_r.bPipe[2].clk;
	// Each port has its own edge, so unrelated or coincident clocks both work
	assign aEdge = aAgree && s_r.aPipe[2].clk && !s_r.aClk;
	assign bEdge = bAgree && s_r.bPipe[2].clk && !s_r.bClk;

	// Port qualification: select low and master enable high
	assign aAct = aEdge && !a.selN && a.en;
	assign bAct = bEdge && !b.selN && b.en;

	// Port-A decode; a full store ignores the write
	assign aFifoWr = aAct && a.wr && !a.mbx && !a.ofsLoad && s_r.irF;
	assign aMailWr = aAct && a.wr && a.mbx;
	assign aMailRd = aAct && !a.wr && a.mbx;
	assign aOfsWr  = aAct && a.wr && !a.mbx && a.ofsLoad;
	assign aSer    = aEdge && !a.serEnN;

	// Port-B decode; reads with output-ready low are dropped
	assign bFifoRd  = bAct && !b.wr && !b.mbx && s_r.orF && !b.rtGo;
	assign bMailWr  = bAct && b.wr && b.mbx;
	assign bMailRd  = bAct && !b.wr && b.mbx;
	assign bMark    = bAct && b.rtMark && !b.rtGo;
	assign bRt      = bAct && b.rtGo && !b.rtMark && s_r.markOn;
	assign bRelease = bAct && b.rtGo && b.rtMark;

	// Store read port, word at the read position
	assign memRd = mem[s_r.rdPtr[AW-1:0]];

	// Next pointers, free space as seen by A, count as seen by B
	assign wrNxt = aFifoWr ? s_r.wrPtr + 1'b1 : s_r.wrPtr;
	assign rdNxt = bRt ? s_r.markPtr : (bFifoRd ? s_r.rdPtr + 1'b1 : s_r.rdPtr);
	assign aFree = DEPTH_C - (wrNxt - gray2bin(s_r.rdSyncA2));
	assign bCnt  = gray2bin(s_r.wrSyncB2) - rdNxt;

	// Next-state logic for both ports
	always_comb begin
		s_nxt = s_r;
		s_nxt.aPipe = {s_r.aPipe[1:0], aIn};
		s_nxt.bPipe = {s_r.bPipe[1:0], bIn};
		if (aAgree) begin
			s_nxt.aClk = s_r.aPipe[2].clk;
		end
		if (bAgree) begin
			s_nxt.bClk = s_r.bPipe[2].clk;
		end
		// Port-A edge work
		if (aEdge) begin
			s_nxt.wrPtr = wrNxt;
			// In retransmit mode the mark guards words from overwrite
			s_nxt.rdSyncA1 = bin2gray(s_r.markOn ? s_r.markPtr : s_r.rdPtr);
			s_nxt.rdSyncA2 = s_r.rdSyncA1;
			// Flags judged on the write just taken, never late
			s_nxt.irF = aFree != '0;
			s_nxt.afN = aFree > {1'b0, s_r.ofsY};
			if (aMailWr) begin
				s_nxt.mail1 = a.data;
			end
			if (aMailRd) begin
				s_nxt.aOut = s_r.mail2;
			end
			// Parallel load beats a serial bit on the same edge
			if (aOfsWr) begin
				s_nxt.ofsX = a.data[`DCF_OFS_X_LSB +: AW];
				s_nxt.ofsY = a.data[`DCF_OFS_Y_LSB +: AW];
			end else if (aSer) begin
				// First bit lands in Y MSB, last in X LSB
				{s_nxt.ofsY, s_nxt.ofsX} = {s_r.ofsY[AW-2:0], s_r.ofsX, a.serData};
			end
		end
		// Port-B edge work
		if (bEdge) begin
			s_nxt.rdPtr = rdNxt;
			s_nxt.wrSyncB1 = bin2gray(s_r.wrPtr);
			s_nxt.wrSyncB2 = s_r.wrSyncB1;
			s_nxt.orF = bCnt != '0;
			s_nxt.aeN = bCnt > {1'b0, s_r.ofsX};
			if (bFifoRd) begin
				s_nxt.bOut = memRd;
			end else if (bMailRd) begin
				s_nxt.bOut = s_r.mail1;
			end
			if (bMailWr) begin
				s_nxt.mail2 = b.data;
			end
			if (bMark) begin
				s_nxt.markPtr = s_r.rdPtr;
				s_nxt.markOn  = 1'b1;
			end else if (bRelease) begin
				s_nxt.markOn = 1'b0;
			end
		end
		// Mail flags: a new word wins over a take in the same cycle
		if (aMailWr) begin
			s_nxt.mail1Full = 1'b1;
		end else if (bMailRd) begin
			s_nxt.mail1Full = 1'b0;
		end
		if (bMailWr) begin
			s_nxt.mail2Full = 1'b1;
		end else if (aMailRd) begin
			s_nxt.mail2Full = 1'b0;
		end
	end

	// State register, synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r      <= '0;
			s_r.afN  <= 1'b1;
			s_r.ofsX <= AW'(X_INIT);
			s_r.ofsY <= AW'(Y_INIT);
		end else begin
			s_r <= s_nxt;
		end
	end

	// Store write port; no reset so it maps onto RAM
	always_ff @(posedge sys_clk) begin
		if (aFifoWr && rst_n) begin
			mem[s_r.wrPtr[AW-1:0]] <= a.data;
		end
	end

	// Outputs
	assign port_a_data_out    = s_r.aOut;
	assign port_b_data_out    = s_r.bOut;
	// Drive only while selected for a read; released in reset
	assign port_a_data_oe     = rst_n && !a.selN && !a.wr;
	assign port_b_data_oe     = rst_n && !b.selN && !b.wr;
	assign input_ready        = s_r.irF;
	assign almost_full_n      = s_r.afN;
	assign output_ready       = s_r.orF;
	assign almost_empty_n     = s_r.aeN;
	assign a_to_b_mail_flag_n = !s_r.mail1Full;
	assign b_to_a_mail_flag_n = !s_r.mail2Full;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking

	sequence aMailWrS;
		aMailWr && !bMailRd;
	endsequence
	sequence bMailRdS;
		bMailRd && !aMailWr;
	endsequence
	sequence bStuckRdS;
		bAct && !b.wr && !b.mbx && !b.rtGo && !b.rtMark && !output_ready;
	endsequence

	ir_reset_a: assert property (!rst_n |=> !input_ready)
		else $error("input ready high after reset");
	a_flag_edge_a: assert property (disable iff (!rst_n)
		($changed(input_ready) || $changed(almost_full_n)) |-> $past(aEdge))
		else $error("port A flag moved off a port A edge");
	b_flag_edge_a: assert property (disable iff (!rst_n)
		($changed(output_ready) || $changed(almost_empty_n)) |-> $past(bEdge))
		else $error("port B flag moved off a port B edge");
	full_write_a: assert property (disable iff (!rst_n)
		(aAct && a.wr && !a.mbx && !a.ofsLoad && !input_ready) |=> $stable(s_r.wrPtr))
		else $error("write taken while full");
	read_hold_a: assert property (disable iff (!rst_n) bStuckRdS |=> $stable(s_r.rdPtr))
		else $error("read taken while not ready");
	fifo_data_a: assert property (disable iff (!rst_n) bFifoRd |=> port_b_data_out == $past(memRd))
		else $error("read data not the stored word");
	ae_level_a: assert property (disable iff (!rst_n)
		bEdge |=> almost_empty_n == ($past(bCnt) > {1'b0, $past(s_r.ofsX)}))
		else $error("almost empty flag wrong");
	af_level_a: assert property (disable iff (!rst_n)
		aEdge |=> almost_full_n == ($past(aFree) > {1'b0, $past(s_r.ofsY)}))
		else $error("almost full flag wrong");
	mail_set_a: assert property (disable iff (!rst_n) aMailWrS |=> !a_to_b_mail_flag_n ##1 1)
		else $error("mail flag not set by write");
	mail_take_a: assert property (disable iff (!rst_n) bMailRdS |=> a_to_b_mail_flag_n)
		else $error("mail flag not cleared by read");
	mail_back_a: assert property (disable iff (!rst_n) bMailWr |=> !b_to_a_mail_flag_n)
		else $error("return mail flag not set");
endmodule

// File: tb/dcf_partner.sv
// Port-B master model: free-running link clock, qualified reads and writes
module dcf_partner (
	// Drive timing
	input  wire logic        sysClk,
	// Port B pins
	output logic             bClk,
	output logic             bSelN,
	output logic             bEn,
	output logic             bWr,
	output logic             bMbx,
	output logic             bMark,
	output logic             bRt,
	output logic [35:0]      bDin,
	input  wire logic [35:0] bPin,
	// Read results to the bench
	output logic             got,
	output logic [35:0]      gotData
);
	timeunit 1ns;
	timeprecision 1ns;

	// Continuous clock, phase unrelated to the system clock
	initial begin
		bClk = 1'b0;
		#137;
		forever #400 bClk = ~bClk;
	end

	// Idle pins; released data wanders so stale values never pass
	initial begin
		{bSelN, bEn, bWr, bMbx, bMark, bRt, got} = 7'h40;
		bDin = 36'h0;
		gotData = 36'h0;
	end
	always @(posedge sysClk) if (bSelN) bDin <= ~bDin;

	// One qualified edge, held across it; a read is taken half a period later, before release
	task automatic op(input logic wr, mbx, mk, rt, input logic [35:0] d);
		@(negedge bClk);
		@(posedge sysClk) #5;
		{bSelN, bEn, bWr, bMbx, bMark, bRt} = {1'b0, 1'b1, wr, mbx, mk, rt};
		if (wr) bDin = d;
		@(posedge bClk);
		@(negedge bClk);
		@(posedge sysClk) #5;
		// The pins still select the port here, so the data output is still driven
		if (!wr) begin
			gotData = bPin;
			got = 1'b1;
		end
		{bSelN, bEn, bWr, bMbx, bMark, bRt} = 6'h20;
		@(posedge sysClk) #5;
		got = 1'b0;
		@(posedge bClk);
	endtask
endmodule

// File: tb/test_dual_clock_fifo_with_mailboxes.sv
// Self-checking bench of the dual-clock FIFO with mailboxes
module test_dual_clock_fifo_with_mailboxes;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEPTH = 16; // Short store keeps fill runs brief
	localparam int THR   = 3;  // Both thresholds, loaded in parallel
	localparam int AW    = $clog2(DEPTH); // Threshold width, serial word is twice this
	logic        sysClk, rstN, aClk, aSelN, aEn, aWr, aMbx, aOfs, aOe, bOe, got;
	logic        aSerEnN, aSerDat; // Serial threshold pins
	logic        inRdy, afN, baN, bClk, bSelN, bEn, bWr, bMbx, bMark, bRt, outRdy, aeN, abN;
	logic [35:0] aDin, aDout, aWire, bDin, bDout, bWire, gotData, w, aGot;
	logic [3:0]  flags;            // Ready and almost flags of both sides
	logic [35:0] expQ[$];          // Expected port-B reads, oldest first
	logic [35:0] words[DEPTH];     // Words accepted by the store
	int          badCount, checkCount, cycles, seed, k;

	assign aWire = aOe ? aDout : aDin;
	assign bWire = bOe ? bDout : bDin;
	assign flags = {inRdy, afN, outRdy, aeN};

	always #50 sysClk = ~sysClk;
	always #400 aClk = ~aClk;
	always @(posedge sysClk) if (aSelN) aDin <= ~aDin;

	dcf_fifo_mailbox #(.DEPTH(DEPTH)) dcf_fifo_mailbox_i (
		.sys_clk(sysClk), .rst_n(rstN), .port_a_clock(aClk), .port_a_select_n(aSelN),
		.port_a_master_enable(aEn), .port_a_write(aWr), .port_a_mailbox_select(aMbx),
		.port_a_offset_load(aOfs), .serial_enable_n(aSerEnN), .serial_data(aSerDat),
		.port_a_data_in(aWire), .port_a_data_out(aDout), .port_a_data_oe(aOe),
		.input_ready(inRdy), .almost_full_n(afN), .b_to_a_mail_flag_n(baN),
		.port_b_clock(bClk), .port_b_select_n(bSelN), .port_b_master_enable(bEn),
		.port_b_write(bWr), .port_b_mailbox_select(bMbx), .port_b_retransmit_mark(bMark),
		.port_b_retransmit(bRt), .port_b_data_in(bWire), .port_b_data_out(bDout),
		.port_b_data_oe(bOe), .output_ready(outRdy), .almost_empty_n(aeN),
		.a_to_b_mail_flag_n(abN)
	);

	dcf_partner dcf_partner_i (
		.sysClk(sysClk), .bClk(bClk), .bSelN(bSelN), .bEn(bEn), .bWr(bWr), .bMbx(bMbx),
		.bMark(bMark), .bRt(bRt), .bDin(bDin), .bPin(bWire), .got(got), .gotData(gotData)
	);

	// Compare, count, report at once
	task automatic check(input logic [35:0] act, exp);
		checkCount++;
		if (act !== exp) begin
			badCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
		end
	endtask

	task automatic reportAndStop();
		$display("checks=%0d mismatches=%0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One port-A transfer, pins held across the qualified edge
	task automatic aOp(input logic wr, mbx, ofs, input logic [35:0] d);
		@(negedge aClk);
		@(posedge sysClk) #5;
		{aSelN, aEn, aWr, aMbx, aOfs} = {1'b0, 1'b1, wr, mbx, ofs};
		aDin = d;
		@(posedge aClk);
		@(negedge aClk);
		@(posedge sysClk) #5;
		// Pin level taken while still selected, so a read shows the driven word
		aGot = aWire;
		{aSelN, aEn, aWr, aMbx, aOfs} = 5'h10;
	endtask

	// Flags cross two synchronizer stages plus a register; five periods covers it
	task automatic settle();
		repeat (5) @(negedge aClk);
	endtask

	// Serial threshold load, first bit to the top of Y, one bit per port-A edge
	task automatic serLoad(input logic [2*AW-1:0] v);
		for (int i = 2 * AW - 1; i >= 0; i--) begin
			@(negedge aClk);
			@(posedge sysClk) #5;
			{aSerEnN, aSerDat} = {1'b0, v[i]};
		end
		@(negedge aClk);
		@(posedge sysClk) #5;
		{aSerEnN, aSerDat} = 2'h2;
	endtask

	function automatic logic [35:0] rnd();
		return {4'($random(seed)), 32'($random(seed))};
	endfunction

	// Watcher: every read result takes the oldest note
	always @(posedge got) begin
		if (expQ.size() == 0)
			check(gotData, ~gotData);
		else
			check(gotData, expQ.pop_front());
	end

	// Hang guard
	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 30000) begin
			badCount++;
			reportAndStop();
		end
	end

	initial begin
		{sysClk, aClk, rstN} = 3'h0;
		{aSelN, aEn, aWr, aMbx, aOfs} = 5'h10;
		{aSerEnN, aSerDat} = 2'h2;
		aDin = 36'h0;
		{badCount, checkCount, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd77};
		repeat (2) @(posedge sysClk);
		#5;
		check(36'(flags), 36'h4);
		check(36'({abN, baN}), 36'h3);
		rstN = 1'b1;
		for (k = 0; k < 100 && inRdy !== 1'b1; k++) @(posedge sysClk);
		check(36'(inRdy), 36'h1);
		aOp(1'b1, 1'b0, 1'b1, 36'(THR) << 16 | 36'(THR));
		// Mail from A to B, then from B to A
		w = rnd();
		aOp(1'b1, 1'b1, 1'b0, w);
		settle();
		check(36'(abN), 36'h0);
		expQ.push_back(w);
		dcf_partner_i.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
		settle();
		check(36'(abN), 36'h1);
		w = rnd();
		dcf_partner_i.op(1'b1, 1'b1, 1'b0, 1'b0, w);
		settle();
		check(36'(baN), 36'h0);
		aOp(1'b0, 1'b1, 1'b0, 36'h0);
		check(aDout, w);
		check(aGot, w);
		settle();
		check(36'(baN), 36'h1);
		check(36'(aOe), 36'h0);
		// Fill past full; the last word must be dropped
		for (k = 0; k <= DEPTH; k++) begin
			w = rnd();
			if (k < DEPTH) words[k] = w;
			aOp(1'b1, 1'b0, 1'b0, w);
			if (k == THR - 1 || k == THR || k == DEPTH - THR - 2 || k == DEPTH - THR - 1) begin
				settle();
				check(36'(flags), 36'({1'b1, DEPTH - k - 1 > THR, 1'b1, k + 1 > THR}));
			end
		end
		settle();
		check(36'(flags), 36'h3);
		// Mark, read two, rewind, read everything
		dcf_partner_i.op(1'b1, 1'b0, 1'b1, 1'b0, 36'h0);
		for (k = 0; k < 2; k++) begin
			expQ.push_back(words[k]);
			dcf_partner_i.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
		end
		dcf_partner_i.op(1'b1, 1'b0, 1'b0, 1'b1, 36'h0);
		for (k = 0; k < DEPTH; k++) begin
			expQ.push_back(words[k]);
			dcf_partner_i.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
			if (k == DEPTH - THR - 2 || k == DEPTH - THR - 1) begin
				settle();
				check(36'(flags), 36'({2'b00, 1'b1, DEPTH - k - 1 > THR}));
			end
		end
		dcf_partner_i.op(1'b1, 1'b0, 1'b1, 1'b1, 36'h0);
		settle();
		check(36'(flags), 36'hC);
		// Read while empty: output holds the last word
		expQ.push_back(words[DEPTH - 1]);
		dcf_partner_i.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
		settle();
		check(36'(flags), 36'hC);
		// Serial load X = 0, Y = DEPTH - 1: one stored word flips both almost flags
		serLoad({AW'(DEPTH - 1), AW'(0)});
		w = rnd();
		aOp(1'b1, 1'b0, 1'b0, w);
		settle();
		check(36'(flags), 36'hB);
		expQ.push_back(w);
		dcf_partner_i.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
		settle();
		check(36'(flags), 36'hC);
		check(36'(expQ.size()), 36'h0);
		reportAndStop();
	end
endmodule
